// >>> hdl/nvs_command_sequencer.sv
module nvs_command_sequencer
    import nvs_pkg::*;
#(
    parameter int BLK_AW = 8,
    parameter logic [7:0] CMD_ERASE_ALL = 8'h08,
    parameter logic [7:0] CMD_UNSECURE = 8'h0B
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // register bus
    input wire logic [BUS_AW-1:0] i_addr,
    input wire logic [BUS_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [BUS_DW-1:0] o_rd_data,
    // stored backdoor key, key 0 in the low word
    input wire logic [63:0] i_stored_key,
    // status out
    output logic o_secured,
    output logic o_irq
);
    typedef struct packed {
        nvs_state_type st;
        logic done_flag;
        logic acc_err;
        logic prot_viol;
        logic mg1;
        logic mg0;
        logic [2:0] idx;
        logic [1:0] key_en;
        logic secured;
        logic key_fail;
        logic special;
        logic [1:0] prot;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [BLK_AW:0] cnt;
        logic blk;
        logic all_blk;
        logic unsec;
        logic [BUS_DW-1:0] rd_data;
        logic irq;
    } nvs_regs_type;

    nvs_regs_type s, next_s;
    logic [NUM_PARAM*16-1:0] words;
    logic [15:0] mem_rdata;
    logic mem_wr;
    logic [BLK_AW:0] mem_addr;
    logic launch;
    logic [7:0] cmd;
    logic [1:0] blk_sel;
    logic [15:0] addr_lo;
    logic [15:0] diff;
    logic [63:0] keys;

    // ==========================================
    // parameter array and flash storage
    nvs_param_array #(
        .NUM(NUM_PARAM)
    ) nvs_param_array_inst (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_wr(i_wr && i_addr == REG_PARAM),
        .i_idx(s.idx),
        .i_wdata(i_wdata),
        .i_lock(!s.done_flag),
        .o_words(words)
    );

    nvs_flash_mem #(
        .AW(BLK_AW + 1)
    ) nvs_flash_mem_inst (
        .i_ref_clk(i_ref_clk),
        .i_wr(mem_wr),
        .i_addr(mem_addr),
        .i_wdata(ERASED_WORD),
        .o_rdata(mem_rdata)
    );

    // ==========================================
    // decoded command words
    assign cmd = words[15:8];
    assign blk_sel = words[1:0];
    assign addr_lo = words[31:16];
    assign keys = words[16*int'(IDX_KEY0) +: 64];
    assign mem_wr = s.st == NVS_ERASE;
    assign mem_addr = {s.blk, s.cnt[BLK_AW-1:0]};
    assign diff = mem_rdata ^ ERASED_WORD;
    // launch refused while an earlier access or protection error is still flagged
    assign launch = i_wr && i_addr == REG_STATUS && i_wdata[BIT_CMD_DONE] && s.done_flag
        && !s.acc_err && !s.prot_viol;

    // ==========================================
    // next state
    always_comb begin
        logic done_ev;
        logic err_ev;
        logic [1:0] irq_next;
        done_ev = 1'b0;
        err_ev = 1'b0;
        irq_next = s.irq_stat;
        next_s = s;

        // register writes
        if (i_wr) begin
            unique case (i_addr)
                REG_STATUS: begin
                    if (i_wdata[BIT_ACC_ERR]) begin
                        next_s.acc_err = 1'b0;
                    end
                    if (i_wdata[BIT_PROT_VIOL]) begin
                        next_s.prot_viol = 1'b0;
                    end
                end
                REG_INDEX: next_s.idx = i_wdata[2:0];
                REG_SECCFG: next_s.key_en = i_wdata[SEC_KEY_EN_LSB +: 2];
                REG_PROTECT: next_s.prot = i_wdata[1:0];
                REG_MODE: next_s.special = i_wdata[MODE_SPECIAL];
                REG_IRQ_STAT: irq_next = s.irq_stat & ~i_wdata[1:0];
                REG_IRQ_MASK: next_s.irq_mask = i_wdata[1:0];
                default: ;
            endcase
        end

        unique case (s.st)
            NVS_IDLE: begin
                if (launch) begin
                    next_s.done_flag = 1'b0;
                    next_s.mg1 = 1'b0;
                    next_s.mg0 = 1'b0;
                    next_s.st = NVS_CHECK;
                end
            end
            NVS_CHECK: begin
                next_s.st = NVS_DONE;
                next_s.cnt = '0;
                if (cmd == CMD_ERASE_BLOCK) begin
                    if (s.idx != IDX_ADDR) begin
                        next_s.acc_err = 1'b1;
                    end else if (blk_sel != BLK_PFLASH && blk_sel != BLK_DFLASH) begin
                        next_s.acc_err = 1'b1;
                    end else if ((blk_sel == BLK_PFLASH && addr_lo[2:0] != 3'h0)
                        || (blk_sel == BLK_DFLASH && addr_lo[0])) begin
                        next_s.acc_err = 1'b1;
                    end else if ((blk_sel == BLK_PFLASH && s.prot[PROT_PFLASH])
                        || (blk_sel == BLK_DFLASH && s.prot[PROT_DFLASH])) begin
                        next_s.prot_viol = 1'b1;
                    end else begin
                        next_s.blk = blk_sel == BLK_PFLASH;
                        next_s.all_blk = 1'b0;
                        next_s.unsec = 1'b0;
                        next_s.st = NVS_ERASE;
                    end
                end else if (cmd == CMD_ERASE_ALL
                    || (cmd == CMD_UNSECURE && s.special)) begin
                    if (s.idx != IDX_CMD) begin
                        next_s.acc_err = 1'b1;
                    end else if (|s.prot) begin
                        next_s.prot_viol = 1'b1;
                    end else begin
                        next_s.blk = 1'b0;
                        next_s.all_blk = 1'b1;
                        next_s.unsec = cmd == CMD_UNSECURE;
                        next_s.st = NVS_ERASE;
                    end
                end else if (cmd == CMD_VERIFY_KEY) begin
                    // a disabled or locked-out check never compares
                    if (s.key_en != KEY_EN_ON || s.key_fail) begin
                        next_s.acc_err = 1'b1;
                    end else begin
                        next_s.st = NVS_KEY;
                    end
                end else begin
                    // unknown codes and unsecure outside special mode
                    next_s.acc_err = 1'b1;
                end
            end
            NVS_ERASE: begin
                next_s.cnt = s.cnt + 1'b1;
                if (s.cnt[BLK_AW-1:0] == '1) begin
                    next_s.cnt = '0;
                    next_s.st = NVS_VERIFY;
                end
            end
            NVS_VERIFY: begin
                // read data lag the address by one cycle
                next_s.cnt = s.cnt + 1'b1;
                if (s.cnt != '0) begin
                    if (|diff) begin
                        next_s.mg1 = 1'b1;
                    end
                    if ((diff & (diff - 16'h0001)) != 16'h0000) begin
                        next_s.mg0 = 1'b1;
                    end
                end
                if (s.cnt[BLK_AW]) begin
                    next_s.cnt = '0;
                    if (s.all_blk && !s.blk) begin
                        next_s.blk = 1'b1;
                        next_s.st = NVS_ERASE;
                    end else begin
                        if (s.unsec) begin
                            next_s.secured = 1'b0;
                        end
                        next_s.st = NVS_DONE;
                    end
                end
            end
            NVS_KEY: begin
                if (keys == i_stored_key) begin
                    next_s.secured = 1'b0;
                end else begin
                    next_s.key_fail = 1'b1;
                end
                next_s.st = NVS_DONE;
            end
            NVS_DONE: begin
                next_s.done_flag = 1'b1;
                done_ev = 1'b1;
                err_ev = s.acc_err || s.prot_viol || s.mg1;
                next_s.st = NVS_IDLE;
            end
            default: next_s.st = NVS_IDLE;
        endcase

        // sticky events: a set in the clearing cycle wins
        next_s.irq_stat = irq_next | {err_ev, done_ev};
        next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

        // register reads, answered in the next cycle
        next_s.rd_data = '0;
        if (i_rd) begin
            unique case (i_addr)
                REG_STATUS: begin
                    next_s.rd_data[BIT_CMD_DONE] = s.done_flag;
                    next_s.rd_data[BIT_ACC_ERR] = s.acc_err;
                    next_s.rd_data[BIT_PROT_VIOL] = s.prot_viol;
                    next_s.rd_data[BIT_VERIFY_ERR] = s.mg1;
                    next_s.rd_data[BIT_VERIFY_UNCORR] = s.mg0;
                end
                REG_INDEX: next_s.rd_data[2:0] = s.idx;
                REG_PARAM: begin
                    // results hidden while busy; unimplemented slots read zero
                    if (s.done_flag && s.idx < 3'(NUM_PARAM)) begin
                        next_s.rd_data = words[16*int'(s.idx) +: 16];
                    end
                end
                REG_SECCFG: begin
                    next_s.rd_data[SEC_KEY_EN_LSB +: 2] = s.key_en;
                    next_s.rd_data[0] = s.secured;
                end
                REG_PROTECT: next_s.rd_data[1:0] = s.prot;
                REG_MODE: next_s.rd_data[MODE_SPECIAL] = s.special;
                REG_IRQ_STAT: next_s.rd_data[1:0] = s.irq_stat;
                REG_IRQ_MASK: next_s.rd_data[1:0] = s.irq_mask;
                default: ;
            endcase
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s <= '0;
            s.st <= NVS_IDLE;
            s.done_flag <= 1'b1;
            s.key_en <= KEY_EN_RESET;
            s.secured <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign o_rd_data = s.rd_data;
    assign o_secured = s.secured;
    assign o_irq = s.irq;

    // ==========================================
    // checks
    launch_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        launch |=> !s.done_flag && s.st == NVS_CHECK)
        else $error("launch did not clear done flag");

    param_lock_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !s.done_flag |=> $stable(words))
        else $error("parameter changed while busy");

    done_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s.st == NVS_DONE |=> s.done_flag && s.st == NVS_IDLE)
        else $error("done flag not returned");

    busy_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_rd && i_addr == REG_PARAM && !s.done_flag |=> o_rd_data == 16'h0000)
        else $error("parameter visible while busy");

    unimpl_slot_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_rd && i_addr == REG_PARAM && s.idx[2:1] == 2'h3 |=> o_rd_data == 16'h0000)
        else $error("unimplemented slot read nonzero");

    blk_index_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s.st == NVS_CHECK && cmd == CMD_ERASE_BLOCK && s.idx != IDX_ADDR
        |=> s.acc_err && s.st == NVS_DONE)
        else $error("block erase index error missed");

    all_index_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s.st == NVS_CHECK && cmd == CMD_ERASE_ALL && s.idx != IDX_CMD |=> s.acc_err)
        else $error("erase all index error missed");

    all_protect_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s.st == NVS_CHECK && cmd == CMD_ERASE_ALL && s.idx == IDX_CMD && |s.prot
        |=> s.prot_viol && s.st != NVS_ERASE)
        else $error("erase all ran on protected flash");

    key_disabled_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s.st == NVS_CHECK && cmd == CMD_VERIFY_KEY && s.key_en != KEY_EN_ON
        |=> s.acc_err && s.st == NVS_DONE && $stable(s.secured))
        else $error("disabled key check not refused");

    key_lockout_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s.st == NVS_KEY && keys != i_stored_key |=> s.key_fail && s.secured == $past(s.secured))
        else $error("key mismatch did not lock out");

    erase_walk_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(s.st == NVS_ERASE) && !s.blk |-> mem_wr ##1 s.cnt == 1)
        else $error("erase walk not advancing");
endmodule

// >>> hdl/nvs_flash_mem.sv
module nvs_flash_mem
    import nvs_pkg::*;
#(
    parameter int AW = 9
) (
    // clock
    input wire logic i_ref_clk,
    // access
    input wire logic i_wr,
    input wire logic [AW-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    // registered read data
    output logic [15:0] o_rdata
);
    // ==========================================
    // array storage, read data always from a register
    logic [15:0] mem [2**AW];
    always_ff @(posedge i_ref_clk) begin
        if (i_wr) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule

// >>> hdl/nvs_param_array.sv
module nvs_param_array
    import nvs_pkg::*;
#(
    parameter int NUM = NUM_PARAM
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // write side
    input wire logic i_wr,
    input wire logic [2:0] i_idx,
    input wire logic [15:0] i_wdata,
    input wire logic i_lock,
    // all words
    output logic [NUM*16-1:0] o_words
);
    // ==========================================
    // one word per index
    for (genvar g = 0; g < NUM; g++) begin : g_word
        typedef struct packed {
            logic [15:0] word;
        } nvs_word_type;
        nvs_word_type s, next_s;
        always_comb begin
            next_s = s;
            // locked words and out-of-range slots never change
            if (i_wr && !i_lock && i_idx == 3'(g)) begin
                next_s.word = i_wdata;
            end
        end
        always_ff @(posedge i_ref_clk) begin
            if (i_rst) begin
                s <= '0;
            end else begin
                s <= next_s;
            end
        end
        assign o_words[g*16 +: 16] = s.word;
    end
endmodule

// >>> hdl/nvs_pkg.sv
package nvs_pkg;
    // ==========================================
    // register bus
    localparam int BUS_AW = 4;
    localparam int BUS_DW = 16;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_INDEX = 4'h1;
    localparam logic [3:0] REG_PARAM = 4'h2;
    localparam logic [3:0] REG_SECCFG = 4'h3;
    localparam logic [3:0] REG_PROTECT = 4'h4;
    localparam logic [3:0] REG_MODE = 4'h5;
    localparam logic [3:0] REG_IRQ_STAT = 4'h6;
    localparam logic [3:0] REG_IRQ_MASK = 4'h7;
    // ==========================================
    // flash_status_register bits
    localparam int BIT_CMD_DONE = 7;
    localparam int BIT_ACC_ERR = 5;
    localparam int BIT_PROT_VIOL = 4;
    localparam int BIT_VERIFY_ERR = 1;
    localparam int BIT_VERIFY_UNCORR = 0;
    // ==========================================
    // security_config_register: key enable field [7:6], secured bit 0 read only
    localparam int SEC_KEY_EN_LSB = 6;
    localparam logic [1:0] KEY_EN_ON = 2'h2;
    localparam logic [1:0] KEY_EN_RESET = 2'h0;
    // protect register bits, mode register bit, irq bits
    localparam int PROT_PFLASH = 0;
    localparam int PROT_DFLASH = 1;
    localparam int MODE_SPECIAL = 0;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERROR = 1;
    // ==========================================
    // parameter array layout
    localparam int NUM_PARAM = 6;
    localparam logic [2:0] IDX_CMD = 3'h0;
    localparam logic [2:0] IDX_ADDR = 3'h1;
    localparam logic [2:0] IDX_KEY0 = 3'h1;
    // ==========================================
    // commands and blocks
    localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
    localparam logic [7:0] CMD_VERIFY_KEY = 8'h0C;
    localparam logic [1:0] BLK_DFLASH = 2'h0;
    localparam logic [1:0] BLK_PFLASH = 2'h3;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [17:0] KEY_BASE_ADDR = 18'h3FF00;
    typedef enum logic [2:0] {
        NVS_IDLE = 3'h0,
        NVS_CHECK = 3'h1,
        NVS_ERASE = 3'h3,
        NVS_VERIFY = 3'h2,
        NVS_DONE = 3'h6,
        NVS_KEY = 3'h7
    } nvs_state_type;
endpackage

// >>> testbench/tb_nvs_command_sequencer.sv
module tb_nvs_command_sequencer;
    import nvs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // signals
    localparam logic [7:0] ERASE_ALL = 8'h08;
    localparam logic [7:0] UNSECURE = 8'h0B;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [BUS_AW-1:0] i_addr = '0;
    logic [BUS_DW-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [63:0] i_stored_key = '0;
    logic [BUS_DW-1:0] o_rd_data;
    logic o_secured;
    logic o_irq;
    int err_count = 0;
    int checks_done = 0;
    logic [15:0] st;
    logic [15:0] w0;
    logic [15:0] w1;

    always #5 i_ref_clk = ~i_ref_clk;

    nvs_command_sequencer #(.BLK_AW(2), .CMD_ERASE_ALL(ERASE_ALL), .CMD_UNSECURE(UNSECURE))
    nvs_command_sequencer_inst (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_stored_key(i_stored_key),
        .o_secured(o_secured), .o_irq(o_irq));

    // ==========================================
    // expectations
    function automatic logic [15:0] exp_stat(input logic acc, input logic prot);
        return {8'h00, 1'b1, 1'b0, acc, prot, 4'h0};
    endfunction

    // block erase address errors: bad block select or misaligned address
    function automatic logic blk_bad(input logic [15:0] a, input logic [15:0] b);
        if (a[1:0] == BLK_PFLASH) return b[2:0] != 3'h0;
        if (a[1:0] == BLK_DFLASH) return b[0];
        return 1'b1;
    endfunction

    // ==========================================
    // bus tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rd_data;
    endtask

    task automatic ld(input logic [2:0] idx, input logic [15:0] d);
        wr(REG_INDEX, {13'h0, idx});
        wr(REG_PARAM, d);
    endtask

    task automatic launch(input logic [2:0] idx);
        wr(REG_INDEX, {13'h0, idx});
        wr(REG_STATUS, 16'h0080);
    endtask

    // bounded poll; a stuck command falls through and fails the status compare
    task automatic wait_done(output logic [15:0] s);
        repeat (100) begin
            rd(REG_STATUS, s);
            if (s[BIT_CMD_DONE] === 1'b1) break;
        end
    endtask

    task automatic run(input string what, input logic [2:0] idx, input logic [15:0] exp);
        logic [15:0] s;
        launch(idx);
        wait_done(s);
        chk(what, exp, s);
        wr(REG_STATUS, 16'h0030);
        wr(REG_IRQ_STAT, 16'h0003);
    endtask

    task automatic keys(input logic [63:0] k);
        for (int i = 0; i < 4; i++) begin
            ld(3'(i + 1), k[i*16+:16]);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog
    initial begin
        #200000;
        err_count++;
        finish_test();
    end

    // ==========================================
    // tests
    initial begin
        void'($urandom(8));
        i_stored_key <= {$urandom(), $urandom()};
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rd(REG_STATUS, st);
        chk("status after reset", 16'h0080, st);
        rd(REG_SECCFG, st);
        chk("security after reset", 16'h0001, st);
        w0 = 16'($urandom());
        wr(4'h8 + 4'(w0[2:0]), w0);
        rd(4'h8 + 4'(w0[2:0]), st);
        chk("unmapped read", 16'h0000, st);
        $display("test reset done");

        for (int i = 6; i < 8; i++) begin
            ld(3'(i), 16'($urandom()) | 16'h0001);
            rd(REG_PARAM, st);
            chk("unused slot", 16'h0000, st);
        end
        w0 = 16'($urandom());
        ld(3'h2, w0);
        rd(REG_PARAM, st);
        chk("data slot", w0, st);
        $display("test slots done");

        wr(REG_IRQ_MASK, 16'h0003);
        w1 = 16'($urandom()) & 16'hFFFE;
        ld(IDX_CMD, {CMD_ERASE_BLOCK, 6'h0, BLK_DFLASH});
        ld(IDX_ADDR, w1);
        launch(IDX_ADDR);
        rd(REG_STATUS, st);
        chk("done while busy", 16'h0000, {15'h0, st[BIT_CMD_DONE]});
        wr(REG_PARAM, ~w1);
        rd(REG_PARAM, st);
        chk("param read busy", 16'h0000, st);
        wait_done(st);
        chk("erase status", exp_stat(1'b0, 1'b0), st);
        rd(REG_PARAM, st);
        chk("locked param", w1, st);
        rd(REG_IRQ_STAT, st);
        chk("irq done", 16'h0001, st & 16'h0001);
        chk("irq pin high", 16'h0001, {15'h0, o_irq});
        wr(REG_IRQ_STAT, 16'h0003);
        repeat (2) @(posedge i_ref_clk);
        #1 chk("irq pin cleared", 16'h0000, {15'h0, o_irq});
        $display("test block erase done");

        run("erase index", IDX_CMD, exp_stat(1'b1, 1'b0));
        for (int k = 0; k < 10; k++) begin
            w0 = {CMD_ERASE_BLOCK, 6'h0, 2'($urandom())};
            w1 = 16'($urandom());
            if (k == 0) w0[1:0] = 2'h1;
            if (k == 1) w0[1:0] = 2'h2;
            if (k == 2) {w0[1:0], w1[2:0]} = {BLK_PFLASH, 3'h4};
            if (k == 3) {w0[1:0], w1[0]} = {BLK_DFLASH, 1'b1};
            ld(IDX_CMD, w0);
            ld(IDX_ADDR, w1);
            run("erase addr", IDX_ADDR, exp_stat(blk_bad(w0, w1), 1'b0));
        end
        wr(REG_PROTECT, 16'h0001);
        ld(IDX_CMD, {CMD_ERASE_BLOCK, 6'h0, BLK_PFLASH});
        ld(IDX_ADDR, 16'h0000);
        run("erase protected", IDX_ADDR, exp_stat(1'b0, 1'b1));
        wr(REG_PROTECT, 16'h0002);
        ld(IDX_CMD, {ERASE_ALL, 8'h00});
        launch(IDX_CMD);
        wait_done(st);
        rd(REG_IRQ_STAT, st);
        chk("irq error", 16'h0002, st & 16'h0002);
        // a pending error blocks the next launch, so clear it first
        wr(REG_STATUS, 16'h0030);
        run("erase all protected", IDX_CMD, exp_stat(1'b0, 1'b1));
        wr(REG_PROTECT, 16'h0000);
        ld(IDX_CMD, {ERASE_ALL, 8'h00});
        run("erase all index", 3'h1, exp_stat(1'b1, 1'b0));
        ld(IDX_CMD, {ERASE_ALL, 8'h00});
        run("erase all", IDX_CMD, exp_stat(1'b0, 1'b0));
        ld(IDX_CMD, {UNSECURE, 8'h00});
        run("unsecure mode", IDX_CMD, exp_stat(1'b1, 1'b0));
        $display("test errors done");

        ld(IDX_CMD, {CMD_VERIFY_KEY, 8'h00});
        keys(i_stored_key);
        run("key disabled", 3'h4, exp_stat(1'b1, 1'b0));
        chk("secured", 16'h0001, {15'h0, o_secured});
        wr(REG_SECCFG, {8'h00, KEY_EN_ON, 6'h0});
        ld(IDX_CMD, {CMD_VERIFY_KEY, 8'h00});
        keys(i_stored_key ^ 64'h0000_0000_0000_0100);
        run("key mismatch", 3'h4, exp_stat(1'b0, 1'b0));
        ld(IDX_CMD, {CMD_VERIFY_KEY, 8'h00});
        keys(i_stored_key);
        run("key locked out", 3'h4, exp_stat(1'b1, 1'b0));
        chk("still secured", 16'h0001, {15'h0, o_secured});
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        wr(REG_SECCFG, {8'h00, KEY_EN_ON, 6'h0});
        ld(IDX_CMD, {CMD_VERIFY_KEY, 8'h00});
        keys(i_stored_key);
        run("key match", 3'h4, exp_stat(1'b0, 1'b0));
        chk("released", 16'h0000, {15'h0, o_secured});
        rd(REG_SECCFG, st);
        chk("security reg", {8'h00, KEY_EN_ON, 6'h0}, st);
        $display("test key check done");

        // unsecure only runs in special mode; reset re-secures first
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        chk("secured after reset", 16'h0001, {15'h0, o_secured});
        wr(REG_MODE, 16'h0001);
        ld(IDX_CMD, {UNSECURE, 8'h00});
        run("unsecure special", IDX_CMD, exp_stat(1'b0, 1'b0));
        chk("unsecured", 16'h0000, {15'h0, o_secured});
        $display("test unsecure done");
        finish_test();
    end
endmodule
